// *** hw/fepc_defines.svh ***
// Constants for the flash erase and protection controller.
// Assumes a byte-addressed flash of 32-bit words behind the controller.
`ifndef FEPC_DEFINES_SVH
`define FEPC_DEFINES_SVH

`define FEPC_FLASH_BYTES   65536
`define FEPC_ERASE_BYTES   1024
`define FEPC_PROT_BYTES    2048
`define FEPC_ADDR_W        16
`define FEPC_WORD_AW       14
`define FEPC_REGIONS       32
`define FEPC_REGION_LSB    11
`define FEPC_UNIT_LSB      10
`define FEPC_UNIT_WORDS_W  8
`define FEPC_ERASED_WORD   32'hFFFFFFFF
`define FEPC_RDATA_RESET   32'h00000000

`endif

// *** hw/fepc_pkg.sv ***
// Types shared by the flash erase and protection controller modules.
// Assumes fepc_defines.svh is on the include path.
`include "fepc_defines.svh"

package fepc_pkg;

  typedef enum logic [2:0] {
    FEPC_ACC_IFETCH  = 3'h0,
    FEPC_ACC_DREAD   = 3'h1,
    FEPC_ACC_DBGREAD = 3'h2,
    FEPC_ACC_PROGRAM = 3'h3,
    FEPC_ACC_ERASE   = 3'h4
  } fepc_kind_t;

  typedef enum logic [3:0] {
    FEPC_ST_IDLE  = 4'h1,
    FEPC_ST_CHECK = 4'h2,
    FEPC_ST_WAIT  = 4'h4,
    FEPC_ST_DONE  = 4'h8
  } fepc_state_t;

  typedef logic [`FEPC_ADDR_W-1:0] fepc_addr_t;

endpackage : fepc_pkg

// *** hw/fepc_chk_if.sv ***
// Carrier between the controller and its protection checker.
// Assumes both ends run on the same clock; the path is combinational.
`timescale 1ns/1ps
`default_nettype none

interface fepc_chk_if;
  import fepc_pkg::*;
  fepc_kind_t kind;
  fepc_addr_t addr;
  logic       allow;

  modport ctrl (output kind, output addr, input allow);
  modport chk  (input kind, input addr, output allow);
endinterface : fepc_chk_if

`default_nettype wire

// *** hw/fepc_prot_check.sv ***
// Protection decision for one access against the per-region settings.
// Assumes the region settings are steady while a request is checked.
`timescale 1ns/1ps
`default_nettype none
`include "fepc_defines.svh"

module fepc_prot_check #(
  parameter int REGIONS = `FEPC_REGIONS
) (
  // Settings
  input  wire logic [REGIONS-1:0] prot_ro,
  input  wire logic [REGIONS-1:0] prot_xo,
  // Request
  fepc_chk_if.chk                 chk
);
  import fepc_pkg::*;

  function automatic logic [4:0] region_of(input fepc_addr_t a);
    region_of = a[`FEPC_ADDR_W-1:`FEPC_REGION_LSB];
  endfunction : region_of

  wire logic [4:0] region  = region_of(chk.addr);
  wire logic       is_ro   = prot_ro[region];
  wire logic       is_xo   = prot_xo[region];
  wire logic       is_mod  = (chk.kind == FEPC_ACC_PROGRAM) || (chk.kind == FEPC_ACC_ERASE);
  wire logic       is_data = (chk.kind == FEPC_ACC_DREAD) || (chk.kind == FEPC_ACC_DBGREAD);

  // Execute-only wins over read-only when both are set, as it is the stricter.
  assign chk.allow = !(is_mod && (is_ro || is_xo))
                  && !(is_data && is_xo);
endmodule : fepc_prot_check

`default_nettype wire

// *** hw/fepc_ctrl.sv ***
// Flash erase and protection controller: accepts fetch, read, program and
// erase requests, checks region protection, then drives the flash word port.
// Assumes a same-clock flash that answers each held request with a one-cycle
// acknowledge and needs no erase of its own: erase writes all-ones words.
//
// Contract
// - The controller addresses a flash array of 64 KB.
// - Erase works on 1-KB units, each erased alone without touching any other.
// - An erased unit reads back with every bit at one.
// - Protection is set per 2-KB region of two adjacent units, each independent.
// - Each region is unprotected, read-only or execute-only.
// - A read-only region refuses every program and erase.
// - An execute-only region refuses program and erase and serves only fetches.
`timescale 1ns/1ps
`default_nettype none
`include "fepc_defines.svh"

module fepc_ctrl #(
  parameter int REGIONS = `FEPC_REGIONS
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  // Protection settings and status
  input  wire logic [REGIONS-1:0]      prot_ro,
  input  wire logic [REGIONS-1:0]      prot_xo,
  input  wire logic                    viol_clr,
  output logic                         viol,
  // Access side
  input  wire logic                    acc_valid,
  input  wire fepc_pkg::fepc_kind_t    acc_kind,
  input  wire fepc_pkg::fepc_addr_t    acc_addr,
  input  wire logic [31:0]             acc_wdata,
  output logic                         acc_ready,
  output logic                         resp_valid,
  output logic                         resp_denied,
  output logic [31:0]                  resp_rdata,
  // Flash side
  output logic                         fl_req,
  output logic                         fl_we,
  output logic [`FEPC_WORD_AW-1:0]     fl_addr,
  output logic [31:0]                  fl_wdata,
  input  wire logic [31:0]             fl_rdata,
  input  wire logic                    fl_ack
);
  import fepc_pkg::*;

  // Word index of a byte address; the two low bits only pick a byte lane.
  function automatic logic [`FEPC_WORD_AW-1:0] word_of(input fepc_addr_t a);
    word_of = a[`FEPC_ADDR_W-1:2];
  endfunction : word_of

  // First word of the 1-KB erase unit that holds a byte address.
  function automatic logic [`FEPC_WORD_AW-1:0] unit_base_of(input fepc_addr_t a);
    unit_base_of = {a[`FEPC_ADDR_W-1:`FEPC_UNIT_LSB], {`FEPC_UNIT_WORDS_W{1'b0}}};
  endfunction : unit_base_of

  // Program and erase are the two kinds that change flash contents.
  function automatic logic writes_flash(input fepc_kind_t k);
    writes_flash = (k == FEPC_ACC_PROGRAM) || (k == FEPC_ACC_ERASE);
  endfunction : writes_flash

  fepc_state_t                   state;
  fepc_state_t                   next_state;
  fepc_kind_t                    kind;
  fepc_kind_t                    next_kind;
  fepc_addr_t                    addr;
  fepc_addr_t                    next_addr;
  logic [31:0]                   wdata;
  logic [31:0]                   next_wdata;
  logic [`FEPC_UNIT_WORDS_W-1:0] erase_cnt;

  fepc_chk_if chk_bus ();

  assign chk_bus.kind = kind;
  assign chk_bus.addr = addr;

  fepc_prot_check #(
    .REGIONS (REGIONS)
  ) u_check (
    .prot_ro (prot_ro),
    .prot_xo (prot_xo),
    .chk     (chk_bus)
  );

  wire logic take      = acc_valid && acc_ready;
  wire logic is_erase  = (kind == FEPC_ACC_ERASE);
  wire logic is_write  = writes_flash(kind);
  wire logic denied    = (state == FEPC_ST_CHECK) && !chk_bus.allow;
  wire logic grant     = (state == FEPC_ST_CHECK) && chk_bus.allow;
  // The last word of a unit is the one whose count has reached all ones.
  wire logic erase_end = (erase_cnt == {`FEPC_UNIT_WORDS_W{1'b1}});
  wire logic op_end    = (state == FEPC_ST_WAIT) && fl_ack && (!is_erase || erase_end);
  wire logic step      = (state == FEPC_ST_WAIT) && fl_ack && !op_end;
  wire logic rd_done   = op_end && !is_write;

  // The word address covers exactly the 64-KB array.
  wire logic [`FEPC_WORD_AW-1:0] word_addr = word_of(addr);
  // Erase starts at the first word of the 1-KB unit holding the address.
  wire logic [`FEPC_WORD_AW-1:0] unit_base = unit_base_of(addr);

  // A refusal skips the flash entirely: the check goes straight to the answer.
  always_comb begin
    next_state = state;
    case (state)
      FEPC_ST_IDLE:  next_state = take ? FEPC_ST_CHECK : FEPC_ST_IDLE;
      FEPC_ST_CHECK: next_state = chk_bus.allow ? FEPC_ST_WAIT : FEPC_ST_DONE;
      FEPC_ST_WAIT:  next_state = op_end ? FEPC_ST_DONE : FEPC_ST_WAIT;
      FEPC_ST_DONE:  next_state = FEPC_ST_IDLE;
      default:       next_state = FEPC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= FEPC_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Request capture; held steady until the answer so the checker sees one value.
  assign next_kind  = take ? acc_kind : kind;
  assign next_addr  = take ? acc_addr : addr;
  assign next_wdata = take ? acc_wdata : wdata;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      kind  <= FEPC_ACC_IFETCH;
      addr  <= '0;
      wdata <= '0;
    end else begin
      kind  <= next_kind;
      addr  <= next_addr;
      wdata <= next_wdata;
    end
  end

  // Ready only when the state machine is about to sit idle, so a request
  // is never taken while an earlier one is still being answered.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_ready <= 1'b1;
    end else begin
      acc_ready <= (next_state == FEPC_ST_IDLE);
    end
  end

  // Flash port. A refused request never gets a grant, so flash stays intact.
  wire logic [`FEPC_WORD_AW-1:0] start_addr = is_erase ? unit_base : word_addr;
  wire logic [31:0]              start_data = is_erase ? `FEPC_ERASED_WORD : wdata;
  // Walk every word of the unit and no word beyond it.
  wire logic [`FEPC_WORD_AW-1:0] step_addr  = fl_addr + {{(`FEPC_WORD_AW-1){1'b0}}, 1'b1};
  wire logic [`FEPC_UNIT_WORDS_W-1:0] step_cnt =
    erase_cnt + {{(`FEPC_UNIT_WORDS_W-1){1'b0}}, 1'b1};
  wire logic                     next_fl_req   = grant || (fl_req && !op_end);
  wire logic                     next_fl_we    = grant ? is_write : (fl_we && !op_end);
  wire logic [`FEPC_WORD_AW-1:0] next_fl_addr  =
    grant ? start_addr : (step ? step_addr : fl_addr);
  wire logic [31:0]              next_fl_wdata = grant ? start_data : fl_wdata;
  wire logic [`FEPC_UNIT_WORDS_W-1:0] next_erase_cnt = grant ? '0 : (step ? step_cnt : erase_cnt);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fl_req <= 1'b0;
      fl_we  <= 1'b0;
    end else begin
      fl_req <= next_fl_req;
      fl_we  <= next_fl_we;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fl_addr   <= '0;
      erase_cnt <= '0;
    end else begin
      fl_addr   <= next_fl_addr;
      erase_cnt <= next_erase_cnt;
    end
  end

  // Kept for the whole walk, so every acknowledged erase word is written as ones.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fl_wdata <= '0;
    end else begin
      fl_wdata <= next_fl_wdata;
    end
  end

  // Answer: one-cycle pulse; data is kept only for a granted read.
  wire logic        next_resp_valid  = denied || op_end;
  wire logic        next_resp_denied = denied;
  // Nothing of a protected region leaks on a refused read.
  wire logic [31:0] next_resp_rdata  =
    rd_done ? fl_rdata : (denied ? `FEPC_RDATA_RESET : resp_rdata);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resp_valid  <= 1'b0;
      resp_denied <= 1'b0;
      resp_rdata  <= `FEPC_RDATA_RESET;
    end else begin
      resp_valid  <= next_resp_valid;
      resp_denied <= next_resp_denied;
      resp_rdata  <= next_resp_rdata;
    end
  end

  // Sticky flag; a new refusal in the clearing cycle wins over the clear.
  wire logic next_viol = denied || (viol && !viol_clr);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      viol <= 1'b0;
    end else begin
      viol <= next_viol;
    end
  end

endmodule : fepc_ctrl

`default_nettype wire

// *** dv/fepc_flash_model.sv ***
// Behavioural flash word store answering the controller's word port.
// Assumes one request at a time; dly adds wait cycles before each ack.
`timescale 1ns/1ps
`default_nettype none
module fepc_flash_model (
  // Clock and word port
  input  wire logic        clk,
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [13:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic [1:0]  dly,
  output logic             ack,
  output logic [31:0]      rdata
);
  logic [31:0] mem [16384];
  logic [1:0]  cnt;
  initial begin
    ack = 1'b0;
    cnt = 2'h0;
    for (int i = 0; i < 16384; i++) mem[i] = 32'(i) ^ 32'h5A5A0000;
  end
  // A plain clocked block, as the initial block also presets ack and the store.
  always @(posedge clk) begin
    ack <= req && !ack && cnt == dly;
    cnt <= (req && !ack && cnt != dly) ? cnt + 2'h1 : 2'h0;
    if (req && ack && we) mem[addr] <= wdata;
  end
  // Outside the ack cycle the data is not valid, so show the inverse.
  assign rdata = ack ? mem[addr] : ~mem[addr];
endmodule : fepc_flash_model
`default_nettype wire

// *** dv/fepc_ctrl_sva.sv ***
// Protocol and protection checks on the controller's ports.
// Assumes binding to fepc_ctrl; one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "fepc_defines.svh"
module fepc_ctrl_sva #(
  parameter int REGIONS = `FEPC_REGIONS
) (
  // Clock and reset
  input wire logic                     clk,
  input wire logic                     rst_b,
  // Protection settings and status
  input wire logic [REGIONS-1:0]       prot_ro,
  input wire logic [REGIONS-1:0]       prot_xo,
  input wire logic                     viol_clr,
  input wire logic                     viol,
  // Access side
  input wire logic                     acc_valid,
  input wire fepc_pkg::fepc_kind_t     acc_kind,
  input wire fepc_pkg::fepc_addr_t     acc_addr,
  input wire logic                     acc_ready,
  input wire logic                     resp_valid,
  input wire logic                     resp_denied,
  input wire logic [31:0]              resp_rdata,
  // Flash side
  input wire logic                     fl_req,
  input wire logic                     fl_we,
  input wire logic [`FEPC_WORD_AW-1:0] fl_addr,
  input wire logic [31:0]              fl_wdata
);
  import fepc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  fepc_kind_t kind_q;
  fepc_addr_t addr_q;
  wire logic take = acc_valid && acc_ready;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) begin
      kind_q <= FEPC_ACC_IFETCH;
      addr_q <= '0;
    end else if (take) begin
      kind_q <= acc_kind;
      addr_q <= acc_addr;
    end
  property p_ro; take && acc_kind >= FEPC_ACC_PROGRAM && prot_ro[acc_addr[15:11]]
    |-> ##2 resp_valid && resp_denied && viol && !fl_req; endproperty
  a_ro: assert property (p_ro) else $error("write to read-only region not refused");
  property p_xo; take && acc_kind inside {FEPC_ACC_DREAD, FEPC_ACC_DBGREAD} &&
    prot_xo[acc_addr[15:11]] |-> ##2 resp_valid && resp_denied && resp_rdata == 32'h0; endproperty
  a_xo: assert property (p_xo) else $error("data read of execute-only region served");
  property p_fetch; take && acc_kind == FEPC_ACC_IFETCH |-> ##2 fl_req && !fl_we; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch not sent to flash");
  property p_ones; fl_req && fl_we && kind_q == FEPC_ACC_ERASE |-> fl_wdata == `FEPC_ERASED_WORD;
  endproperty
  a_ones: assert property (p_ones) else $error("erase word not all ones");
  property p_unit; fl_req && kind_q == FEPC_ACC_ERASE |-> fl_addr[13:8] == addr_q[15:10];
  endproperty
  a_unit: assert property (p_unit) else $error("erase left its unit");
  property p_word; fl_req && kind_q != FEPC_ACC_ERASE |-> fl_addr == addr_q[15:2]; endproperty
  a_word: assert property (p_word) else $error("flash word address wrong");
  property p_sticky; viol && !viol_clr |=> viol; endproperty
  a_sticky: assert property (p_sticky) else $error("violation flag dropped");
  property p_clr; $fell(viol) |-> $past(viol_clr); endproperty
  a_clr: assert property (p_clr) else $error("violation flag cleared unasked");
  property p_quiet; resp_valid && resp_denied |-> !fl_req && !$past(fl_req); endproperty
  a_quiet: assert property (p_quiet) else $error("refused access reached flash");
endmodule : fepc_ctrl_sva
bind fepc_ctrl fepc_ctrl_sva #(.REGIONS(REGIONS)) sva_u (.clk, .rst_b, .viol_clr, .viol,
  .acc_valid, .acc_ready, .resp_valid, .resp_denied, .fl_req, .fl_we, .prot_ro, .prot_xo,
  .acc_kind, .acc_addr, .resp_rdata, .fl_wdata, .fl_addr);
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench for the flash erase and protection controller.
// Assumes the flash model starts with a known word pattern.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fepc_pkg::*;
  logic clk = 0, rst_b = 0, viol_clr = 0, acc_valid = 0, dn;
  logic acc_ready, resp_valid, resp_denied, viol, fl_req, fl_we, fl_ack;
  logic [31:0] prot_ro = 0, prot_xo = 0, acc_wdata = 0, resp_rdata, fl_rdata, fl_wdata, rd;
  fepc_kind_t acc_kind = FEPC_ACC_IFETCH;
  fepc_addr_t acc_addr = 0;
  logic [13:0] fl_addr;
  logic [1:0]  dly = 0;
  int err_count = 0, compares = 0;
  always #2 clk = ~clk;
  fepc_ctrl dut_u (.clk, .rst_b, .prot_ro, .prot_xo, .viol_clr, .viol, .acc_valid,
    .acc_kind, .acc_addr, .acc_wdata, .acc_ready, .resp_valid, .resp_denied, .resp_rdata,
    .fl_req, .fl_we, .fl_addr, .fl_wdata, .fl_rdata, .fl_ack);
  fepc_flash_model fl_u (.clk, .req(fl_req), .we(fl_we), .addr(fl_addr), .wdata(fl_wdata),
    .dly, .ack(fl_ack), .rdata(fl_rdata));
  function automatic logic [31:0] pat(int w);
    return 32'(w) ^ 32'h5A5A0000;
  endfunction : pat
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic acc(fepc_kind_t k, logic [15:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    #1 acc_valid = 1; acc_kind = k; acc_addr = a; acc_wdata = d;
    chk("acc_ready", 1, acc_ready);
    @(posedge clk);
    #1 acc_valid = 0;
    chk("acc_busy", 0, acc_ready);
    while (resp_valid !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1 n++;
    end
    chk("resp_valid", 1, resp_valid);
    dn = resp_denied;
    rd = resp_rdata;
    @(posedge clk);
    #1 chk("resp_pulse", 0, resp_valid);
  endtask : acc
  task automatic t_rw;
    acc(FEPC_ACC_PROGRAM, 16'h0804, 32'hA5A51234); chk("prog", 0, dn);
    acc(FEPC_ACC_DREAD, 16'h0804, 0); chk("rd", 32'hA5A51234, rd);
    acc(FEPC_ACC_DBGREAD, 16'hFFFC, 0); chk("top", pat(14'h3FFF), rd);
  endtask : t_rw
  task automatic t_erase;
    dly = 2;
    acc(FEPC_ACC_ERASE, 16'h0E00, 0); chk("erase", 0, dn);
    dly = 0;
    acc(FEPC_ACC_DREAD, 16'h0C00, 0); chk("first", 32'hFFFFFFFF, rd);
    acc(FEPC_ACC_DREAD, 16'h0FFC, 0); chk("last", 32'hFFFFFFFF, rd);
    acc(FEPC_ACC_DREAD, 16'h1000, 0); chk("above", pat(14'h400), rd);
    acc(FEPC_ACC_DREAD, 16'h0BFC, 0); chk("below", pat(14'h2FF), rd);
  endtask : t_erase
  task automatic t_prot;
    prot_ro[2] = 1; prot_ro[5] = 1; prot_xo[5] = 1;
    for (int k = 0; k < 5; k++) begin
      acc(fepc_kind_t'(k), 16'h1004, 0); chk("ro", k >= 3, dn);
      if (k >= 3) chk("viol", 1, viol);
      acc(fepc_kind_t'(k), 16'h2808, 0); chk("xo", k != 0, dn);
      if (k < 3) chk("xo_data", (k == 0) ? pat(14'hA02) : 32'h0, rd);
    end
    acc(FEPC_ACC_DREAD, 16'h1004, 0); chk("ro_kept", pat(14'h401), rd);
    acc(FEPC_ACC_PROGRAM, 16'h1800, 1); chk("next_region", 0, dn);
    #1 viol_clr = 1;
    @(posedge clk);
    #1 viol_clr = 0;
    chk("viol_clr", 0, viol);
  endtask : t_prot
  task automatic t_reset;
    acc(FEPC_ACC_ERASE, 16'h1000, 0); chk("rst_pre", 1, viol);
    rst_b = 0;
    #1 chk("rst_viol", 0, viol);
    chk("rst_ready", 1, acc_ready);
    repeat (2) @(posedge clk);
    #1 rst_b = 1;
    acc(FEPC_ACC_IFETCH, 16'h2808, 0); chk("rst_fetch", pat(14'hA02), rd);
    chk("rst_flag", 0, viol);
  endtask : t_reset
  task automatic results;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  initial begin
    #100000 err_count++;
    results();
  end
  initial begin
    repeat (6) @(posedge clk);
    #1 rst_b = 1;
    t_rw();
    t_erase();
    t_prot();
    t_reset();
    results();
  end
endmodule : tb
`default_nettype wire
